// ===== src/cpu_core_map.vh
// Summary of operation
// - program counter is 10 bits, addressing 1024 words of 14 bits
// - fetching starts at address 0 after reset; interrupts vector to 4
// - data address 0 goes through pointer zero, address 1 through pointer one
// - each pointer keeps only seven bits, reaching only the 128-byte space
// - direct file field selects 00h..7Fh; 08h..7Fh is general data memory
// - power-down flag set by sleep, cleared by writing zero or reset
// - destination bit 0 writes working register, 1 writes the file location
// - bit ops take 3-bit position; set, clear or test without flag change
// - taken skip discards the fetched instruction and runs a no-op instead
// - skip-on-zero inc/dec store result, change no flag; plain inc/dec set zero
// - call pushes next address, loads literal address, takes two cycles
// - computed jump loads pc plus one plus sign-extended working register, two cycles
// - add sums working register and file byte, updating carry, digit carry, zero
// - add with carry also adds carry flag, updating carry, digit carry, zero
// - clear file writes zero and always sets the zero flag
// - complement inverts the file byte to the destination, updating zero only
// - both register moves copy one byte in one cycle without flag changes
// - and of working register and file byte goes to destination, zero only
// - flag register holds external and timer flags; enables add a global enable
// - no halt operation; sleep is the only low-power instruction
// - rotates shift file byte through carry, one position left or right
// - interrupt return pops the pc and sets the global enable
`ifndef CPU_CORE_MAP_VH
`define CPU_CORE_MAP_VH
// data space offsets
`define ADR_INDIRECT_ZERO   7'h00
`define ADR_INDIRECT_ONE    7'h01
`define ADR_POINTER_ZERO    7'h02
`define ADR_POINTER_ONE     7'h03
`define ADR_STATUS          7'h04
`define ADR_WORKING         7'h05
`define ADR_IRQ_FLAGS       7'h06
`define ADR_IRQ_ENABLES     7'h07
`define ADR_FIRST_EXTERNAL  7'h08
// status fields
`define ST_POWER_DOWN_BIT   5
`define ST_DIGIT_CARRY_BIT  2
`define ST_CARRY_BIT        1
`define ST_ZERO_BIT         0
// interrupt fields
`define IRQ_EXT_BIT         1
`define IRQ_TIMER_BIT       0
`define IRQ_GLOBAL_BIT      7
// vectors
`define RESET_VECTOR        10'h000
`define IRQ_VECTOR          10'h004
// opcode groups in bits 13:12
`define GRP_BYTE            2'b00
`define GRP_BIT             2'b01
`define GRP_BRANCH          2'b10
`define GRP_LITERAL         2'b11
// byte-op codes in bits 11:8
`define OP_MISC             4'h0
`define OP_MOVE_CLEAR       4'h1
`define OP_ADD              4'h2
`define OP_INC              4'h3
`define OP_INC_SKIP         4'h4
`define OP_DEC              4'h5
`define OP_DEC_SKIP         4'h6
`define OP_SUB              4'h7
`define OP_COMPLEMENT       4'h8
`define OP_MOVE_FROM        4'h9
`define OP_ADD_CARRY        4'hA
`define OP_AND              4'hB
`define OP_OR               4'hC
`define OP_XOR              4'hD
`define OP_ROT_LEFT         4'hE
`define OP_SUB_CARRY        4'hF
// misc codes in bits 7:0
`define MISC_RETURN         8'h01
`define MISC_IRQ_RETURN     8'h02
`define MISC_SLEEP          8'h03
`define MISC_COMPUTED_JUMP  8'h04
// literal codes in bits 11:8
`define LIT_ADD             4'h0
`define LIT_SUB             4'h1
`define LIT_AND             4'h2
`define LIT_OR              4'h3
`define LIT_XOR             4'h4
`define LIT_MOVE            4'h5
`define LIT_RETURN          4'h6
`define LIT_ROT_RIGHT       4'h8
`endif

// ===== src/lcd_mcu_cpu_core.v
`timescale 1ns/1ns
`include "cpu_core_map.vh"
module lcd_mcu_cpu_core #(
   parameter STACK_DEPTH = 4,    // return stack entries
   parameter SP_W        = 2     // stack index width
) (
   input  wire        clk,          // 50 MHz system clock
   input  wire        rstn,         // asynchronous reset, active low
   output reg  [9:0]  rom_addr_q,   // program address
   input  wire [13:0] rom_data,     // instruction word for rom_addr_q
   output reg  [6:0]  dm_addr_q,    // data space address
   output reg  [7:0]  dm_wdata_q,   // data space write byte
   output reg         dm_we_q,      // data space write strobe
   input  wire [7:0]  dm_rdata,     // data space read byte for dm_addr_q
   input  wire        ext_irq_evt,  // external input interrupt event
   input  wire        timer_irq_evt,// timer interrupt event
   output reg         power_down_q, // power-down flag
   output reg         sleeping_q    // core halted awaiting wake-up
);
   localparam [3:0] S_FETCH  = 4'b0001;
   localparam [3:0] S_DECODE = 4'b0010;
   localparam [3:0] S_EXEC   = 4'b0100;
   localparam [3:0] S_SLEEP  = 4'b1000;

   reg [3:0]  state_q;
   reg [9:0]  pc_q;
   reg [13:0] ir_q;
   reg [7:0]  w_q;
   reg [6:0]  ptr0_q;
   reg [6:0]  ptr1_q;
   reg        c_q;
   reg        dc_q;
   reg        z_q;
   reg [1:0]  flags_q;
   reg [1:0]  enables_q;
   reg        gie_q;
   reg        flush_q;
   reg        flush_adv_q;
   reg [SP_W-1:0] sp_q;
   reg [9:0]  stk_q [0:STACK_DEPTH-1];

   wire [1:0] pending  = flags_q & enables_q;
   wire [9:0] stk_top  = stk_q[sp_q - 1'b1];
   wire [9:0] pc_inc   = pc_q + 10'h001;

   // effective address of the instruction word now on the rom bus
   reg [6:0] ea_d;
   always @* begin
      ea_d = rom_data[6:0];
      if (rom_data[6:0] == `ADR_INDIRECT_ZERO)
         ea_d = ptr0_q;
      else if (rom_data[6:0] == `ADR_INDIRECT_ONE)
         ea_d = ptr1_q;
   end

   // operand read: core registers live here, the rest comes from the data port
   reg [7:0] fv;
   always @* begin
      case (dm_addr_q)
         `ADR_INDIRECT_ZERO: fv = 8'h00; // pointer aimed at itself reads zero
         `ADR_INDIRECT_ONE:  fv = 8'h00;
         `ADR_POINTER_ZERO:  fv = {1'b0, ptr0_q};
         `ADR_POINTER_ONE:   fv = {1'b0, ptr1_q};
         `ADR_STATUS:        fv = {2'b00, power_down_q, 2'b00, dc_q, c_q, z_q};
         `ADR_WORKING:       fv = w_q;
         `ADR_IRQ_FLAGS:     fv = {6'h00, flags_q};
         `ADR_IRQ_ENABLES:   fv = {gie_q, 5'h00, enables_q};
         default:            fv = dm_rdata;
      endcase
   end

   // instruction fields
   wire [1:0] grp  = ir_q[13:12];
   wire [3:0] sub  = ir_q[11:8];
   wire       dbit = ir_q[7];
   wire [7:0] k8   = ir_q[7:0];
   wire [2:0] bsel = ir_q[9:7];
   wire [7:0] bmask = 8'h01 << bsel;

   // shared adder for all add and subtract forms
   reg  [7:0] add_a;
   reg  [7:0] add_b;
   reg        add_cin;
   wire [8:0] add_sum = {1'b0, add_a} + {1'b0, add_b} + {8'h00, add_cin};
   wire [4:0] add_low = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};

   reg [7:0] res;
   reg       wr_f;
   reg       wr_w;
   reg       upd_z;
   reg       upd_c;
   reg       upd_dc;
   reg       new_c;
   reg       skip;
   reg       branch;
   reg [9:0] pc_n;
   reg       push;
   reg       pop;
   reg       set_gie;
   reg       do_sleep;

   // decode and execute one instruction word
   always @* begin
      add_a = fv;
      add_b = w_q;
      add_cin = 1'b0;
      res = fv;
      wr_f = 1'b0;
      wr_w = 1'b0;
      upd_z = 1'b0;
      upd_c = 1'b0;
      upd_dc = 1'b0;
      new_c = add_sum[8];
      skip = 1'b0;
      branch = 1'b0;
      pc_n = pc_inc;
      push = 1'b0;
      pop = 1'b0;
      set_gie = 1'b0;
      do_sleep = 1'b0;
      case (grp)
         `GRP_BYTE: begin
            wr_w = ~dbit;
            wr_f = dbit;
            case (sub)
               `OP_MISC: begin
                  wr_w = 1'b0;
                  wr_f = 1'b0;
                  case (k8)
                     `MISC_RETURN: begin
                        pop = 1'b1;
                        branch = 1'b1;
                        pc_n = stk_top;
                     end
                     `MISC_IRQ_RETURN: begin
                        pop = 1'b1;
                        branch = 1'b1;
                        pc_n = stk_top;
                        set_gie = 1'b1;
                     end
                     `MISC_SLEEP: do_sleep = 1'b1;
                     `MISC_COMPUTED_JUMP: begin
                        branch = 1'b1;
                        pc_n = pc_inc + {{2{w_q[7]}}, w_q};
                     end
                     default: pc_n = pc_inc;
                  endcase
               end
               `OP_MOVE_CLEAR: begin
                  wr_w = 1'b0;
                  wr_f = 1'b1;
                  if (dbit)
                     res = w_q;
                  else begin
                     res = 8'h00;
                     upd_z = 1'b1;
                  end
               end
               `OP_ADD: begin
                  res = add_sum[7:0];
                  {upd_c, upd_dc, upd_z} = 3'b111;
               end
               `OP_INC: begin
                  res = fv + 8'h01;
                  upd_z = 1'b1;
               end
               `OP_INC_SKIP: begin
                  res = fv + 8'h01;
                  skip = (res == 8'h00);
               end
               `OP_DEC: begin
                  res = fv - 8'h01;
                  upd_z = 1'b1;
               end
               `OP_DEC_SKIP: begin
                  res = fv - 8'h01;
                  skip = (res == 8'h00);
               end
               `OP_SUB: begin
                  add_b = ~w_q;
                  add_cin = 1'b1;
                  res = add_sum[7:0];
                  {upd_c, upd_dc, upd_z} = 3'b111;
               end
               `OP_COMPLEMENT: begin
                  res = ~fv;
                  upd_z = 1'b1;
               end
               `OP_MOVE_FROM: begin
                  wr_w = 1'b1;
                  wr_f = 1'b0;
               end
               `OP_ADD_CARRY: begin
                  add_cin = c_q;
                  res = add_sum[7:0];
                  {upd_c, upd_dc, upd_z} = 3'b111;
               end
               `OP_AND: begin
                  res = fv & w_q;
                  upd_z = 1'b1;
               end
               `OP_OR: begin
                  res = fv | w_q;
                  upd_z = 1'b1;
               end
               `OP_XOR: begin
                  res = fv ^ w_q;
                  upd_z = 1'b1;
               end
               `OP_ROT_LEFT: begin
                  res = {fv[6:0], c_q};
                  new_c = fv[7];
                  upd_c = 1'b1;
               end
               default: begin // subtract with carry
                  add_b = ~w_q;
                  add_cin = c_q;
                  res = add_sum[7:0];
                  {upd_c, upd_dc, upd_z} = 3'b111;
               end
            endcase
         end
         `GRP_BIT: begin
            case (ir_q[11:10])
               2'b00: begin
                  res = fv & ~bmask;
                  wr_f = 1'b1;
               end
               2'b01: begin
                  res = fv | bmask;
                  wr_f = 1'b1;
               end
               2'b10:   skip = ((fv & bmask) == 8'h00);
               default: skip = ((fv & bmask) != 8'h00);
            endcase
         end
         `GRP_BRANCH: begin
            branch = 1'b1;
            pc_n = ir_q[9:0];
            push = ~ir_q[11];
         end
         default: begin
            wr_w = 1'b1;
            add_a = k8;
            case (sub)
               `LIT_ADD: begin
                  res = add_sum[7:0];
                  {upd_c, upd_dc, upd_z} = 3'b111;
               end
               `LIT_SUB: begin
                  add_b = ~w_q;
                  add_cin = 1'b1;
                  res = add_sum[7:0];
                  {upd_c, upd_dc, upd_z} = 3'b111;
               end
               `LIT_AND: begin
                  res = k8 & w_q;
                  upd_z = 1'b1;
               end
               `LIT_OR: begin
                  res = k8 | w_q;
                  upd_z = 1'b1;
               end
               `LIT_XOR: begin
                  res = k8 ^ w_q;
                  upd_z = 1'b1;
               end
               `LIT_MOVE: res = k8;
               `LIT_RETURN: begin
                  res = k8;
                  pop = 1'b1;
                  branch = 1'b1;
                  pc_n = stk_top;
               end
               `LIT_ROT_RIGHT: begin
                  wr_w = ~dbit;
                  wr_f = dbit;
                  res = {c_q, fv[7:1]};
                  new_c = fv[0];
                  upd_c = 1'b1;
               end
               default: wr_w = 1'b0;
            endcase
         end
      endcase
   end

   wire exec_live = (state_q == S_EXEC) && !flush_q;
   wire irq_take  = (state_q == S_FETCH) && gie_q && (pending != 2'b00) && !flush_q;
   wire [SP_W-1:0] sp_wr = sp_q;

   // return stack, one entry per generate slot
   genvar gi;
   generate
      for (gi = 0; gi < STACK_DEPTH; gi = gi + 1) begin : g_stack
         always @(posedge clk or negedge rstn) begin
            if (!rstn)
               stk_q[gi] <= 10'h000;
            else if (irq_take && sp_wr == gi)
               stk_q[gi] <= pc_q;
            else if (exec_live && push && sp_wr == gi)
               stk_q[gi] <= pc_inc;
         end
      end
   endgenerate

   // sequencer: fetch, decode, execute; each instruction cycle is three clocks
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q     <= S_FETCH;
         pc_q        <= `RESET_VECTOR;
         rom_addr_q  <= `RESET_VECTOR;
         ir_q        <= 14'h0000;
         dm_addr_q   <= 7'h00;
         flush_q     <= 1'b0;
         flush_adv_q <= 1'b0;
         sp_q        <= {SP_W{1'b0}};
         sleeping_q  <= 1'b0;
      end else begin
         case (state_q)
            S_FETCH: begin
               if (irq_take) begin
                  sp_q       <= sp_q + 1'b1;
                  pc_q       <= `IRQ_VECTOR;
                  rom_addr_q <= `IRQ_VECTOR;
               end else
                  state_q <= S_DECODE;
            end
            S_DECODE: begin
               ir_q      <= rom_data;
               dm_addr_q <= ea_d;
               state_q   <= S_EXEC;
            end
            S_EXEC: begin
               state_q <= S_FETCH;
               if (flush_q) begin
                  // the discarded slot runs as a no-op
                  flush_q    <= 1'b0;
                  pc_q       <= flush_adv_q ? pc_inc : pc_q;
                  rom_addr_q <= flush_adv_q ? pc_inc : pc_q;
               end else begin
                  pc_q        <= pc_n;
                  rom_addr_q  <= pc_n;
                  flush_q     <= skip | branch;
                  flush_adv_q <= skip;
                  if (push)
                     sp_q <= sp_q + 1'b1;
                  else if (pop)
                     sp_q <= sp_q - 1'b1;
                  if (do_sleep) begin
                     state_q    <= S_SLEEP;
                     sleeping_q <= 1'b1;
                  end
               end
            end
            S_SLEEP: begin
               // only an enabled flag wakes the core; a flag left set would wake at once
               if (pending != 2'b00) begin
                  state_q    <= S_FETCH;
                  sleeping_q <= 1'b0;
               end
            end
            default: state_q <= S_FETCH;
         endcase
      end
   end

   // external data port: write strobe follows the execute clock for one clock
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dm_we_q    <= 1'b0;
         dm_wdata_q <= 8'h00;
      end else begin
         dm_we_q    <= exec_live && wr_f && (dm_addr_q >= `ADR_FIRST_EXTERNAL);
         dm_wdata_q <= res;
      end
   end

   wire f_wr = exec_live && wr_f;

   // core registers; flag updates come after the file write so they win
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         w_q          <= 8'h00;
         ptr0_q       <= 7'h00;
         ptr1_q       <= 7'h00;
         c_q          <= 1'b0;
         dc_q         <= 1'b0;
         z_q          <= 1'b0;
         power_down_q <= 1'b0;
         enables_q    <= 2'b00;
         gie_q        <= 1'b0;
      end else begin
         if (f_wr && dm_addr_q == `ADR_POINTER_ZERO)
            ptr0_q <= res[6:0];
         if (f_wr && dm_addr_q == `ADR_POINTER_ONE)
            ptr1_q <= res[6:0];
         if (f_wr && dm_addr_q == `ADR_STATUS) begin
            // software may only clear the flag; a one written here is ignored
            power_down_q <= power_down_q & res[`ST_POWER_DOWN_BIT];
            dc_q <= res[`ST_DIGIT_CARRY_BIT];
            c_q  <= res[`ST_CARRY_BIT];
            z_q  <= res[`ST_ZERO_BIT];
         end
         if (exec_live && (wr_w || (wr_f && dm_addr_q == `ADR_WORKING)))
            w_q <= res;
         if (f_wr && dm_addr_q == `ADR_IRQ_ENABLES) begin
            enables_q <= {res[`IRQ_EXT_BIT], res[`IRQ_TIMER_BIT]};
            gie_q     <= res[`IRQ_GLOBAL_BIT];
         end
         if (exec_live && upd_c)
            c_q <= new_c;
         if (exec_live && upd_dc)
            dc_q <= add_low[4];
         if (exec_live && upd_z)
            z_q <= (res == 8'h00);
         if (exec_live && do_sleep)
            power_down_q <= 1'b1;
         if (exec_live && set_gie)
            gie_q <= 1'b1;
         if (irq_take)
            gie_q <= 1'b0;
      end
   end

   // interrupt flags: an event in the clearing clock still lands
   always @(posedge clk or negedge rstn) begin
      if (!rstn)
         flags_q <= 2'b00;
      else if (f_wr && dm_addr_q == `ADR_IRQ_FLAGS)
         flags_q <= {res[`IRQ_EXT_BIT], res[`IRQ_TIMER_BIT]}
                    | {ext_irq_evt, timer_irq_evt};
      else
         flags_q <= flags_q | {ext_irq_evt, timer_irq_evt};
   end
endmodule

// ===== src/README_unused.v
`timescale 1ns/1ns

// ===== dv/cpu_core_checker.sv
`timescale 1ns/1ns
module cpu_core_checker #(
   parameter STACK_DEPTH = 4, // return stack entries
   parameter SP_W        = 2  // stack index width
) (
   input wire        clk,           // system clock
   input wire        rstn,          // async reset, active low
   input wire [9:0]  rom_addr_q,    // program address
   input wire [13:0] rom_data,      // instruction word
   input wire [6:0]  dm_addr_q,     // data address
   input wire [7:0]  dm_wdata_q,    // write byte
   input wire        dm_we_q,       // write strobe
   input wire [7:0]  dm_rdata,      // read byte
   input wire        ext_irq_evt,   // external event
   input wire        timer_irq_evt, // timer event
   input wire        power_down_q,  // power-down flag
   input wire        sleeping_q     // core stopped
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // a fetched word stands a full instruction cycle unless the vector cuts it short
   sequence s_word_holds;
      $stable(rom_addr_q) [*2];
   endsequence
   sequence s_vector_taken;
      rom_addr_q == 10'h004;
   endsequence
   // the flag and the stop come from the same edge of the sleep instruction
   sequence s_sleep_entry;
      $rose(sleeping_q) ##0 power_down_q;
   endsequence

   a_reset_fetch_zero: assert property ($rose(rstn) |-> (rom_addr_q == 10'h000) [*3])
      else $error("first fetch after reset not at address zero");
   a_word_cycle: assert property ($changed(rom_addr_q) |=> (s_vector_taken or s_word_holds))
      else $error("program address did not stand for an instruction cycle");
   a_we_external_only: assert property (dm_we_q |-> dm_addr_q >= 7'h08)
      else $error("core register address reached the data port");
   a_we_single_pulse: assert property (dm_we_q |=> !dm_we_q [*2])
      else $error("write strobe longer than one clock or too close");
   a_we_addr_steady: assert property (dm_we_q |-> $stable(dm_addr_q))
      else $error("data address moved under a write");
   a_pd_with_sleep: assert property ($rose(power_down_q) |-> s_sleep_entry)
      else $error("power-down flag rose without sleep");
   a_sleep_keeps_pd: assert property (sleeping_q |-> power_down_q)
      else $error("sleeping without power-down flag");
   a_sleep_pc_frozen: assert property (sleeping_q && $past(sleeping_q) |-> $stable(rom_addr_q))
      else $error("program address moved while asleep");
   a_sleep_no_write: assert property (sleeping_q |-> !dm_we_q)
      else $error("data write while asleep");
endmodule

bind lcd_mcu_cpu_core cpu_core_checker #(.STACK_DEPTH(STACK_DEPTH), .SP_W(SP_W)) chk_u (
   .clk(clk), .rstn(rstn), .rom_addr_q(rom_addr_q), .rom_data(rom_data),
   .dm_addr_q(dm_addr_q), .dm_wdata_q(dm_wdata_q), .dm_we_q(dm_we_q), .dm_rdata(dm_rdata),
   .ext_irq_evt(ext_irq_evt), .timer_irq_evt(timer_irq_evt),
   .power_down_q(power_down_q), .sleeping_q(sleeping_q));

// ===== dv/code_data_store.sv
`timescale 1ns/1ns
module code_data_store (
   input  wire        clk,        // system clock
   input  wire [9:0]  rom_addr_q, // program address from the core
   output wire [13:0] rom_data,   // instruction word, combinational
   input  wire [6:0]  dm_addr_q,  // data address from the core
   input  wire [7:0]  dm_wdata_q, // write byte
   input  wire        dm_we_q,    // write strobe
   output wire [7:0]  dm_rdata    // read byte, combinational
);
   // program store of 1024 words of 14 bits, loaded by the bench
   logic [13:0] rom [0:1023];
   logic [7:0]  ram [0:127];
   assign rom_data = rom[rom_addr_q];
   // no wait states: the core samples one clock after setting the address
   assign dm_rdata = ram[dm_addr_q];
   // write lands at the edge that closes the strobe clock
   always @(posedge clk) begin
      if (dm_we_q) begin
         ram[dm_addr_q] <= dm_wdata_q;
      end
   end
endmodule

// ===== dv/testbench.sv
`timescale 1ns/1ns
module testbench;
   logic        clk;
   logic        rstn;
   logic        ext_irq_evt;
   logic        timer_irq_evt;
   wire  [9:0]  rom_addr_q;
   wire  [13:0] rom_data;
   wire  [6:0]  dm_addr_q;
   wire  [7:0]  dm_wdata_q;
   wire         dm_we_q;
   wire  [7:0]  dm_rdata;
   wire         power_down_q;
   wire         sleeping_q;
   int          miscompares;
   int          checked;
   logic [31:0] rng_q;
   logic [3:0]  op;
   logic [7:0]  a;
   logic [7:0]  b;
   logic        c;
   logic        d;
   logic [10:0] r;
   localparam logic [3:0] alu_ops [7] = '{4'h2, 4'h7, 4'hA, 4'hB, 4'h8, 4'h3, 4'hE};
   // vector at 4 parks after storing a marker; main code starts at 8, subroutine at 20h
   localparam logic [13:0] dir_prog [37] = '{14'h2808, 0, 0, 0, 14'h3599, 14'h01C8, 14'h2806,
      0, 14'h35D0, 14'h0182, 14'h355A, 14'h0180, 14'h0143, 14'h35FF, 14'h01C4, 14'h04C4,
      14'h01C5, 14'h2020, 14'h01C6, 14'h3582, 14'h0187, 14'h0003, 14'h0000, 14'h2817,
      0, 0, 0, 0, 0, 0, 0, 0, 14'h3502, 14'h0004, 14'h01C7, 14'h01C7, 14'h3677};

   lcd_mcu_cpu_core dut_u (.clk(clk), .rstn(rstn), .rom_addr_q(rom_addr_q), .rom_data(rom_data),
      .dm_addr_q(dm_addr_q), .dm_wdata_q(dm_wdata_q), .dm_we_q(dm_we_q), .dm_rdata(dm_rdata),
      .ext_irq_evt(ext_irq_evt), .timer_irq_evt(timer_irq_evt),
      .power_down_q(power_down_q), .sleeping_q(sleeping_q));
   code_data_store store_u (.clk(clk), .rom_addr_q(rom_addr_q), .rom_data(rom_data),
      .dm_addr_q(dm_addr_q), .dm_wdata_q(dm_wdata_q), .dm_we_q(dm_we_q), .dm_rdata(dm_rdata));

   // 50 MHz system clock
   initial clk = 1'b0;
   always #10 clk = ~clk;

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   // expected {dc, c, z, result}; logic ops keep carry, dc stays at its reset zero,
   // and a rotate leaves zero as the bit write left it (clear)
   function automatic logic [10:0] alu(input logic [3:0] o, input logic [7:0] f,
                                       input logic [7:0] w, input logic ci);
      logic [8:0] s;
      logic [4:0] h;
      h = 5'h00;
      case (o)
         4'h2: begin
            s = {1'b0, f} + {1'b0, w};
            h = {1'b0, f[3:0]} + {1'b0, w[3:0]};
         end
         4'hA: begin
            s = {1'b0, f} + {1'b0, w} + {8'h00, ci};
            h = {1'b0, f[3:0]} + {1'b0, w[3:0]} + {4'h0, ci};
         end
         4'h7: begin
            s = {1'b0, f} + {1'b0, ~w} + 9'h001;
            h = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
         end
         4'hB: s = {ci, f & w};
         4'h3: s = {ci, f + 8'h01};
         4'hE: s = {f, ci};
         default: s = {ci, ~f};
      endcase
      return {h[4], s[8], o != 4'hE && s[7:0] == 8'h00, s[7:0]};
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("compares %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // reset and blank memories; unwritten data reads a known pattern
   task automatic hold_reset;
      @(negedge clk);
      rstn = 1'b0;
      for (int i = 0; i < 1024; i++) store_u.rom[i] = 14'h0000;
      for (int i = 0; i < 128; i++) store_u.ram[i] = 8'hA5;
   endtask

   task automatic release_reset;
      repeat (5) @(negedge clk);
      rstn = 1'b1;
   endtask

   // bounded wait for a program address or for sleep, then let the last write land
   task automatic wait_for(input logic on_sleep, input logic [9:0] pc);
      int n;
      for (n = 0; n < 3000; n++) begin
         @(negedge clk);
         if (on_sleep ? sleeping_q === 1'b1 : rom_addr_q === pc) break;
      end
      if (n == 3000) begin
         miscompares++;
         $display("Error at %0t ns: core did not arrive", $time);
         tally_and_finish;
      end
      repeat (4) @(negedge clk);
   endtask

   initial begin
      rstn = 1'b0;
      ext_irq_evt = 1'b0;
      timer_irq_evt = 1'b0;
      miscompares = 0;
      checked = 0;
      rng_q = 32'h0000_0001;
      // arithmetic and logic ops: set carry, load operand, operate, store W and status
      for (int k = 0; k < 20; k++) begin
         rng_q = xorshift(rng_q);
         op = alu_ops[k % 7];
         {c, d, a, b} = rng_q[17:0];
         if (k < 7) {a, b} = 16'hFF01;
         hold_reset;
         store_u.rom[0] = 14'h1084 | {3'b000, c, 10'h000};
         store_u.rom[1] = {6'h35, a};
         store_u.rom[2] = 14'h01C0;
         store_u.rom[3] = {6'h35, b};
         store_u.rom[4] = {2'b00, op, d, 7'h40};
         store_u.rom[5] = 14'h01C2;
         store_u.rom[6] = 14'h0904;
         store_u.rom[7] = 14'h01C1;
         store_u.rom[8] = 14'h2808;
         release_reset;
         wait_for(1'b0, 10'h008);
         r = alu(op, a, b, c);
         check(store_u.ram[7'h40], d ? r[7:0] : a);
         check(store_u.ram[7'h42], d ? b : r[7:0]);
         check(store_u.ram[7'h41] & 8'h27, {5'h00, r[10:8]});
         $display("alu test %0d done", k);
      end
      // pointer, clear, skip, call, computed jump, sleep and wake by interrupt
      hold_reset;
      for (int i = 0; i < 37; i++) store_u.rom[i] = dir_prog[i];
      release_reset;
      wait_for(1'b1, 10'h000);
      check(store_u.ram[7'h50], 8'h5A);
      check(store_u.ram[7'h43], 8'h00);
      check(store_u.ram[7'h44], 8'h00);
      check(store_u.ram[7'h45], 8'hA5);
      check(store_u.ram[7'h46], 8'h77);
      check(store_u.ram[7'h47], 8'hA5);
      check({7'h00, power_down_q}, 8'h01);
      // timer event is not enabled, so the core must stay asleep
      timer_irq_evt = 1'b1;
      @(negedge clk);
      timer_irq_evt = 1'b0;
      repeat (20) @(negedge clk);
      check({7'h00, sleeping_q}, 8'h01);
      ext_irq_evt = 1'b1;
      @(negedge clk);
      ext_irq_evt = 1'b0;
      wait_for(1'b0, 10'h006);
      check(store_u.ram[7'h48], 8'h99);
      // with the global enable cleared the still-set flag must not re-enter the handler
      check(rom_addr_q[7:0], 8'h06);
      check({6'h00, sleeping_q, power_down_q}, 8'h01);
      $display("directed test done");
      tally_and_finish;
   end
endmodule
